// ### logic/brm_pkg.sv
// package: shared constants and types for the breaker-ready reclose monitor
package brm_pkg;
   // time base: one tick of the common device time base
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
   // timer settings are counted in ticks
   localparam int TMR_W = 16;
   // dynamic block time 0.5 s, in ticks of 1 ms
   localparam int unsigned DYN_BLOCK_MS = 500;
   localparam logic [TMR_W-1:0] DYN_BLOCK_TICKS = TMR_W'(DYN_BLOCK_MS * 1000 / TICK_US);
   localparam int MAX_CYCLES = 8;
   localparam int CYC_W = 4;
   localparam int PICKUP_TYPES = 4;
   localparam int PU_W = 2;
   localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
   localparam logic [CYC_W-1:0] CYC_ZERO = 4'h0;

   // which position inputs are assigned
   typedef enum logic [1:0] {
      BRM_AUX_NONE = 2'h0,
      BRM_AUX_OPEN = 2'h1,
      BRM_AUX_CLOSED = 2'h2,
      BRM_AUX_BOTH = 2'h3
   } brm_aux_e;

   // reclose control mode
   typedef enum logic {
      BRM_CTRL_TRIP = 1'b0,
      BRM_CTRL_PICKUP = 1'b1
   } brm_ctrl_e;

   // decoded breaker position
   typedef enum logic [1:0] {
      BRM_POS_CLOSED = 2'h0,
      BRM_POS_OPEN = 2'h1,
      BRM_POS_MID = 2'h2
   } brm_pos_e;

   // settings bundle, all times in ticks
   typedef struct packed {
      brm_aux_e aux_cfg;
      brm_ctrl_e ctrl_mode;
      logic per_cycle_ready_check;
      logic [CYC_W-1:0] num_cycles;
      logic [TMR_W-1:0] dead_time_trip;
      logic [PICKUP_TYPES-1:0][TMR_W-1:0] dead_time_pickup;
      logic [TMR_W-1:0] reclaim_time;
      logic [TMR_W-1:0] breaker_recovery_timeout;
      logic [TMR_W-1:0] dead_time_max_extension;
      logic [TMR_W-1:0] dynamic_block_time;
   } brm_cfg_s;

   // status indications
   typedef struct packed {
      logic reclose_blocked_flag;
      logic reclose_not_ready_flag;
      logic breaker_not_ready_flag;
      logic running;
      logic [CYC_W-1:0] cycle;
   } brm_stat_s;
endpackage : brm_pkg

// ### logic/brm_tick.sv
// time base divider producing a one-cycle tick pulse
`timescale 1ns/100ps
`default_nettype none
module brm_tick #(
   parameter int unsigned DIV = brm_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // tick out
   output logic o_tick
);
   import brm_pkg::*;
   localparam int W = $clog2(DIV + 1);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   wire wrap = (cnt_q == LAST);
   assign cnt_d = wrap ? '0 : cnt_q + W'(1);
   assign o_tick = wrap;

   // free-running divider, cleared by device reset
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
endmodule : brm_tick
`default_nettype wire

// ### logic/brm_timer.sv
// loadable tick-based down counter
`timescale 1ns/100ps
`default_nettype none
module brm_timer #(
   parameter int W = brm_pkg::TMR_W
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // control
   input wire logic i_tick,
   input wire logic i_load,
   input wire logic [W-1:0] i_value,
   input wire logic i_clear,
   // state
   output logic o_run,
   output logic [W-1:0] o_remain,
   output logic o_expire
);
   import brm_pkg::*;
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic run_q;
   logic run_d;
   // expiry when the last tick is consumed
   wire last = run_q && i_tick && (cnt_q <= W'(1));
   assign o_expire = last && !i_load && !i_clear;
   always_comb
   begin
      cnt_d = cnt_q;
      run_d = run_q;
      if (i_load)
      begin
         // zero-length setting still expires on the next tick
         cnt_d = i_value;
         run_d = 1'b1;
      end
      else if (i_clear || last)
      begin
         cnt_d = '0;
         run_d = 1'b0;
      end
      else if (run_q && i_tick)
         cnt_d = cnt_q - W'(1);
   end
   assign o_run = run_q;
   assign o_remain = cnt_q;

   // counter state
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end
endmodule : brm_timer
`default_nettype wire

// ### logic/brm_monitor.sv
// breaker-ready monitor and three-pole reclose sequencer
// Summary of operation
// - start only if breaker ready at first trip
// - optionally wait for readiness before each reclose
// - recovery timer starts when ready input falls while idle
// - per-cycle check: ready drop starts timer, no block
// - ready returns early: clear timer, continue
// - timer running at dead end: extend dead time
// - ready returns within extension: resume, clear timer
// - timer running past max extension: dynamic block
// - recovery timer expiry in dead time or extension: dynamic block
// - dynamic block: no close, reset after block time
// - no position inputs: trip drives dead start
// - open-only: open without trip blocks, flags
// - open-only: dead starts when open goes active
// - closed/pole inputs: dead starts when input drops
// - both inputs: decode open, closed, intermediate
// - both: intermediate or untripped open blocks
// - static/dynamic block flags plus breaker-not-ready cause
// - dead time ends: close and start reclaim
// - pickup mode selects dead time by pickup type
// - reclaim expiry resets; fault there starts the next cycle, or is final once no cycles remain or i_block is active
// - up to eight reclose cycles
// - dynamic block locks out restart, then quiescent
`timescale 1ns/100ps
`default_nettype none
module brm_monitor #(
   parameter int unsigned TICK_DIV = brm_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // settings
   input wire brm_pkg::brm_cfg_s i_cfg,
   // protection side
   input wire logic i_trip,
   input wire logic [brm_pkg::PU_W-1:0] i_pickup_type,
   input wire logic i_block,
   // breaker side
   input wire logic i_breaker_ready_input,
   input wire logic i_breaker_open_input,
   input wire logic i_breaker_closed_input,
   input wire logic [2:0] i_per_pole_position_inputs,
   input wire logic i_use_per_pole,
   // outputs
   output logic o_close_cmd,
   output brm_pkg::brm_stat_s o_status
);
   import brm_pkg::*;

   // sequencer states, gray along idle-trip-dead-ext-reclaim
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_TRIP = 3'b001,
      ST_DEAD = 3'b011,
      ST_EXT = 3'b010,
      ST_RECLAIM = 3'b110,
      ST_DYN = 3'b111
   } brm_state_e;

   brm_state_e state_q;
   brm_state_e state_d;
   logic [CYC_W-1:0] cyc_q;
   logic [CYC_W-1:0] cyc_d;
   logic close_q;
   logic close_d;
   logic ready_q; // previous ready level for edge detection
   logic trip_q; // previous trip level
   logic not_rdy_q; // breaker-not-ready cause latch
   logic not_rdy_d;
   logic [PU_W-1:0] pu_q; // pickup type captured during trip
   logic tick;

   // time base
   brm_tick #(.DIV(TICK_DIV)) u_tick (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .o_tick(tick)
   );

   // position decode: closed-side signal, per pole if assigned
   wire closed_sig = i_use_per_pole ? (|i_per_pole_position_inputs) : i_breaker_closed_input;
   brm_pos_e pos;
   always_comb
   begin
      unique case (i_cfg.aux_cfg)
         BRM_AUX_NONE: pos = BRM_POS_CLOSED;
         BRM_AUX_OPEN: pos = i_breaker_open_input ? BRM_POS_OPEN : BRM_POS_CLOSED;
         BRM_AUX_CLOSED: pos = closed_sig ? BRM_POS_CLOSED : BRM_POS_OPEN;
         BRM_AUX_BOTH: pos = (i_breaker_open_input && !i_breaker_closed_input) ? BRM_POS_OPEN :
            (!i_breaker_open_input && i_breaker_closed_input) ? BRM_POS_CLOSED :
            BRM_POS_MID;
      endcase
   end

   wire idle = (state_q == ST_IDLE);
   wire running = !idle && (state_q != ST_DYN);
   // breaker open or intermediate with no trip present is implausible
   wire no_trip_open = (i_cfg.aux_cfg != BRM_AUX_NONE) && !i_trip &&
      ((pos == BRM_POS_OPEN) || (pos == BRM_POS_MID));
   // dead time start criterion, by position input allocation
   wire trip_fall = trip_q && !i_trip;
   wire dead_go = (i_cfg.aux_cfg == BRM_AUX_NONE) ? trip_fall :
      (pos == BRM_POS_OPEN);
   wire ready_fall = ready_q && !i_breaker_ready_input;
   wire trip_rise = i_trip && !trip_q;

   // dead time selection by control mode
   wire [TMR_W-1:0] dead_val = (i_cfg.ctrl_mode == BRM_CTRL_PICKUP) ?
      i_cfg.dead_time_pickup[pu_q] : i_cfg.dead_time_trip;

   // timer controls
   logic dead_load;
   logic ext_load;
   logic rcl_load;
   logic dyn_load;
   logic mon_load;
   logic mon_clear;
   logic dead_exp;
   logic ext_exp;
   logic rcl_exp;
   logic dyn_exp;
   logic mon_exp;
   logic mon_run;
   logic [TMR_W-1:0] mon_rem;

   // recovery timer: starts on ready falling edge while idle or with the per-cycle check, cleared when ready returns
   assign mon_load = ready_fall && (idle || i_cfg.per_cycle_ready_check);
   // clear terms come from the ready input, registered state and the other timers only, never from
   // state_d, which itself depends on this timer's expiry (a combinational loop)
   assign mon_clear = i_breaker_ready_input || (state_q == ST_DYN && dyn_exp) ||
      (state_q == ST_RECLAIM && rcl_exp);

   brm_timer u_mon (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_tick(tick),
      .i_load(mon_load), .i_value(i_cfg.breaker_recovery_timeout), .i_clear(mon_clear),
      .o_run(mon_run), .o_remain(mon_rem), .o_expire(mon_exp));
   brm_timer u_dead (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_tick(tick),
      .i_load(dead_load), .i_value(dead_val), .i_clear(state_q != ST_DEAD),
      .o_run(), .o_remain(), .o_expire(dead_exp));
   brm_timer u_ext (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_tick(tick),
      .i_load(ext_load), .i_value(i_cfg.dead_time_max_extension),
      .i_clear(state_q != ST_EXT), .o_run(), .o_remain(), .o_expire(ext_exp));
   brm_timer u_rcl (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_tick(tick),
      .i_load(rcl_load), .i_value(i_cfg.reclaim_time), .i_clear(state_q != ST_RECLAIM),
      .o_run(), .o_remain(), .o_expire(rcl_exp));
   brm_timer u_dyn (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_tick(tick),
      .i_load(dyn_load), .i_value(i_cfg.dynamic_block_time), .i_clear(state_q != ST_DYN),
      .o_run(), .o_remain(), .o_expire(dyn_exp));

   // close may be released only when the breaker is ready (if checked)
   wire close_ok = !i_cfg.per_cycle_ready_check || (i_breaker_ready_input && !mon_run);
   wire more_cycles = (cyc_q < i_cfg.num_cycles) && (cyc_q < CYC_W'(MAX_CYCLES));

   // sequencer next state
   always_comb
   begin
      state_d = state_q;
      cyc_d = cyc_q;
      close_d = 1'b0;
      dead_load = 1'b0;
      ext_load = 1'b0;
      rcl_load = 1'b0;
      dyn_load = 1'b0;
      not_rdy_d = not_rdy_q;
      unique case (state_q)
         ST_IDLE:
         begin
            not_rdy_d = no_trip_open || !i_breaker_ready_input;
            // only a ready, unblocked breaker may start a cycle
            if (trip_rise && !i_block && !no_trip_open && i_breaker_ready_input
               && i_cfg.num_cycles != CYC_ZERO)
            begin
               state_d = ST_TRIP;
               cyc_d = CYC_ZERO;
            end
         end
         ST_TRIP:
         begin
            if (i_block)
            begin
               state_d = ST_DYN;
               dyn_load = 1'b1;
            end
            else if (dead_go)
            begin
               state_d = ST_DEAD;
               dead_load = 1'b1;
            end
         end
         ST_DEAD, ST_EXT:
         begin
            // recovery expiry, blocking or implausible opening abort the attempt
            if (mon_exp || i_block || (state_q == ST_EXT && ext_exp && mon_run)
               || (i_trip && !trip_q) || (i_cfg.aux_cfg == BRM_AUX_BOTH && pos == BRM_POS_MID))
            begin
               state_d = ST_DYN;
               dyn_load = 1'b1;
               not_rdy_d = mon_exp || mon_run || (pos == BRM_POS_MID);
            end
            else if ((state_q == ST_DEAD && dead_exp) || state_q == ST_EXT)
            begin
               if (close_ok)
               begin
                  close_d = 1'b1;
                  rcl_load = 1'b1;
                  cyc_d = cyc_q + CYC_W'(1);
                  state_d = ST_RECLAIM;
               end
               else if (state_q == ST_DEAD)
               begin
                  state_d = ST_EXT;
                  ext_load = 1'b1;
               end
            end
         end
         ST_RECLAIM:
         begin
            if (trip_rise)
            begin
               // new fault: next cycle if allowed, else final trip
               if (more_cycles && !i_block)
                  state_d = ST_TRIP;
               else
               begin
                  state_d = ST_DYN;
                  dyn_load = 1'b1;
               end
            end
            else if (rcl_exp)
               state_d = ST_IDLE;
         end
         ST_DYN:
         begin
            // restart locked until the blocking time runs out
            if (dyn_exp)
            begin
               state_d = ST_IDLE;
               not_rdy_d = 1'b0;
            end
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   // registered state
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_q <= ST_IDLE;
         cyc_q <= CYC_ZERO;
         close_q <= 1'b0;
         ready_q <= 1'b0;
         trip_q <= 1'b0;
         not_rdy_q <= 1'b0;
         pu_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         cyc_q <= cyc_d;
         close_q <= close_d;
         ready_q <= i_breaker_ready_input;
         trip_q <= i_trip;
         not_rdy_q <= not_rdy_d;
         pu_q <= i_trip ? i_pickup_type : pu_q;
      end
   end

   // indications
   assign o_close_cmd = close_q;
   assign o_status.reclose_blocked_flag = idle && (i_block || no_trip_open);
   assign o_status.reclose_not_ready_flag = (state_q == ST_DYN);
   assign o_status.breaker_not_ready_flag = not_rdy_q;
   assign o_status.running = running;
   assign o_status.cycle = cyc_q;
endmodule : brm_monitor
`default_nettype wire

// ### bench/brm_chk_monitor.sv
// checker: port-level assertions for the reclose monitor
`timescale 1ns/100ps
`default_nettype none
module brm_chk
   import brm_pkg::*;
#(
   parameter int unsigned TICK_DIV = 10
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // watched inputs
   input wire brm_pkg::brm_cfg_s i_cfg,
   input wire logic i_trip,
   input wire logic [1:0] i_pickup_type,
   input wire logic i_block,
   input wire logic i_breaker_ready_input,
   input wire logic i_breaker_open_input,
   input wire logic i_breaker_closed_input,
   input wire logic [2:0] i_per_pole_position_inputs,
   input wire logic i_use_per_pole,
   // watched outputs
   input wire logic o_close_cmd,
   input wire brm_pkg::brm_stat_s o_status
);
   logic idle_w; // neither running nor dynamically blocked
   assign idle_w = !o_status.running && !o_status.reclose_not_ready_flag;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   // dead time starts once the trip drops in a running cycle
   sequence s_dead_start;
      $fell(i_trip) && o_status.running;
   endsequence
   // the attempt ends in a close or a dynamic block, never hangs
   sequence s_attempt_end;
      ##[1:300] (o_close_cmd || o_status.reclose_not_ready_flag);
   endsequence
   AST_DEAD_ENDS: assert property (s_dead_start |-> s_attempt_end)
      else $error("attempt did not finish");
   AST_CLOSE_PULSE: assert property (o_close_cmd |=> !o_close_cmd)
      else $error("close longer than one cycle");
   AST_CLOSE_CLEAN: assert property (o_close_cmd |-> o_status.running &&
      !o_status.reclose_not_ready_flag) else $error("close outside a live cycle");
   AST_CYCLE_LIMIT: assert property (o_close_cmd |-> o_status.cycle <= i_cfg.num_cycles)
      else $error("too many closes");
   AST_DYN_HOLD: assert property ($rose(o_status.reclose_not_ready_flag) |->
      o_status.reclose_not_ready_flag [*8]) else $error("dynamic block too short");
   AST_DYN_END: assert property ($rose(o_status.reclose_not_ready_flag) |->
      ##[1:1000] !o_status.reclose_not_ready_flag) else $error("dynamic block stuck");
   AST_NOT_READY: assert property ($rose(i_trip) && idle_w && !i_breaker_ready_input |=>
      !o_status.running [*2]) else $error("started with breaker not ready");
   AST_STATIC_BLK: assert property (idle_w && i_block |-> o_status.reclose_blocked_flag)
      else $error("static block not flagged");
   AST_OPEN_BLK: assert property (idle_w && i_cfg.aux_cfg == BRM_AUX_OPEN &&
      i_breaker_open_input && !i_trip |-> o_status.reclose_blocked_flag)
      else $error("open without trip not blocked");
   AST_RESET_QUIET: assert property ($rose(i_resetn) |-> !o_close_cmd &&
      !o_status.running) else $error("active after reset");
endmodule : brm_chk
bind brm_monitor brm_chk #(.TICK_DIV(TICK_DIV)) i_chk (
   .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_cfg(i_cfg), .i_trip(i_trip),
   .i_pickup_type(i_pickup_type), .i_block(i_block),
   .i_breaker_ready_input(i_breaker_ready_input), .i_breaker_open_input(i_breaker_open_input),
   .i_breaker_closed_input(i_breaker_closed_input),
   .i_per_pole_position_inputs(i_per_pole_position_inputs), .i_use_per_pole(i_use_per_pole),
   .o_close_cmd(o_close_cmd), .o_status(o_status));
`default_nettype wire

// ### bench/brm_brk_model.sv
// partner model: breaker contacts and mechanism readiness
`timescale 1ns/100ps
`default_nettype none
module brm_brk_model (
   // clock
   input wire logic i_clk_sys,
   // commands
   input wire logic i_trip,
   input wire logic i_close_cmd,
   // scenario controls: hold ready low, recovery cycles, forced position
   input wire logic i_hold_ready,
   input wire logic [15:0] i_rec_cyc,
   input wire logic [1:0] i_force,
   // contacts
   output logic o_ready,
   output logic o_open,
   output logic o_closed
);
   logic [15:0] cnt_q = 16'h0000; // recovery cycles left
   logic open_q = 1'b0;
   logic closed_q = 1'b1;
   logic trip_q = 1'b0; // trip as the device took it at the rising edge
   // sample trip on the rising edge so the contacts react half a cycle after the device
   // took the trip, with no race against the bench's falling-edge stimulus
   always @(posedge i_clk_sys)
      trip_q <= i_trip;
   // ready falls when a trip opens the closed breaker and returns only after recovery
   assign o_ready = (cnt_q == 16'h0000) && !i_hold_ready;
   assign o_open = open_q;
   assign o_closed = closed_q;
   // contacts move at the falling edge, clear of the sampling edge
   always @(negedge i_clk_sys)
   begin
      if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
      if (i_force == 2'h1 || (trip_q && closed_q))
      begin
         open_q <= 1'b1;
         closed_q <= 1'b0;
         if (i_force != 2'h1) cnt_q <= i_rec_cyc;
      end
      else if (i_force == 2'h2)
      begin
         open_q <= 1'b0; // both contacts off: intermediate
         closed_q <= 1'b0;
      end
      else if (i_force == 2'h3 || i_close_cmd)
      begin
         open_q <= 1'b0;
         closed_q <= 1'b1;
      end
   end
endmodule : brm_brk_model
`default_nettype wire

// ### bench/tb_top.sv
// testbench: directed reclose sequences against the breaker model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
   import brm_pkg::*;
   localparam int TD = 10; // short tick keeps the run brief
   logic clk = 1'b0, resetn = 1'b0, trip = 1'b0, blk = 1'b0, hold_rdy = 1'b0, pp = 1'b0;
   logic [1:0] pu = 2'h0, fpos = 2'h0;
   logic [15:0] rec = 16'h0000;
   logic rdy, bo, bc, close;
   brm_cfg_s cfg;
   brm_stat_s st;
   int n_errors = 0, samples_checked = 0, n;
   int recs[4] = '{20, 50, 95, 200};
   logic [15:0] tmos[4] = '{16'h000a, 16'h000a, 16'h000a, 16'h0005};
   logic [1:0] fcs[5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h0};
   logic [4:0] exp_blk = 5'h1d;
   initial forever #5 clk = ~clk;
   brm_monitor #(.TICK_DIV(TD)) i_dut (.i_clk_sys(clk), .i_resetn(resetn), .i_cfg(cfg),
      .i_trip(trip), .i_pickup_type(pu), .i_block(blk), .i_breaker_ready_input(rdy),
      .i_breaker_open_input(bo), .i_breaker_closed_input(bc),
      .i_per_pole_position_inputs({3{bc}}), .i_use_per_pole(pp),
      .o_close_cmd(close), .o_status(st));
   brm_brk_model i_brk (.i_clk_sys(clk), .i_trip(trip), .i_close_cmd(close),
      .i_hold_ready(hold_rdy), .i_rec_cyc(rec), .i_force(fpos), .o_ready(rdy),
      .o_open(bo), .o_closed(bc));
   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask : tick
   // wait, bounded, until the function is quiescent again
   task automatic idle_wait;
      for (n = 0; n < 3000 && (st.running || st.reclose_not_ready_flag); n++) tick(1);
      `CHK(st.running | st.reclose_not_ready_flag, 1'b0)
      tick(3);
   endtask : idle_wait
   // one trip held five cycles; close expected near base cycles after its rise
   task automatic shot(input logic exp_close, input int base);
      tick(1);
      trip = 1'b1;
      for (n = 0; n < 400 && !close && !st.reclose_not_ready_flag; n++)
      begin
         tick(1);
         if (n == 4) trip = 1'b0;
      end
      trip = 1'b0;
      `CHK(close, exp_close)
      if (exp_close) `CHK(n >= base - 12 && n <= base + 12, 1'b1)
   endtask : shot
   // put the breaker back to closed
   task automatic reclose_breaker;
      fpos = 2'h3;
      tick(1);
      fpos = 2'h0;
   endtask : reclose_breaker
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   // watchdog: the sequence needs well under ten thousand cycles
   initial
   begin
      repeat (30000) @(posedge clk);
      n_errors++;
      complete_run();
   end
   initial
   begin
      cfg = '{aux_cfg: BRM_AUX_NONE, ctrl_mode: BRM_CTRL_TRIP, per_cycle_ready_check: 1'b0,
         num_cycles: 4'h1, dead_time_trip: 16'h0004, dead_time_pickup: '{16'h000b, 16'h0008,
         16'h0005, 16'h0002}, reclaim_time: 16'h0006, breaker_recovery_timeout: 16'h000a,
         dead_time_max_extension: 16'h0003, dynamic_block_time: 16'h0006};
      tick(3);
      resetn = 1'b1;
      `CHK({close, st.running, st.cycle}, 6'h00)
      tick(2);
      // one full cycle for each position-input assignment
      for (int a = 0; a < 4; a++)
      begin
         cfg.aux_cfg = brm_aux_e'(a);
         pp = (a == 2); // closed side read through the per-pole inputs once
         shot(1'b1, (a == 0) ? 5 + 4 * TD : 1 + 4 * TD);
         `CHK(st.cycle, 4'h1)
         idle_wait();
      end
      $display("test positions done");
      // dead time chosen by pickup type
      cfg.aux_cfg = BRM_AUX_NONE;
      cfg.ctrl_mode = BRM_CTRL_PICKUP;
      for (int k = 0; k < 4; k++)
      begin
         pu = 2'(k);
         shot(1'b1, 5 + (2 + 3 * k) * TD);
         idle_wait();
      end
      $display("test pickup done");
      // two attempts, then a final trip inside the reclaim time
      cfg.ctrl_mode = BRM_CTRL_TRIP;
      cfg.num_cycles = 4'h2;
      shot(1'b1, 5 + 4 * TD);
      shot(1'b1, 5 + 4 * TD);
      `CHK(st.cycle, 4'h2)
      shot(1'b0, 0);
      `CHK(st.reclose_not_ready_flag, 1'b1)
      for (n = 0; n < 300 && st.reclose_not_ready_flag; n++) tick(1);
      `CHK(n >= 6 * TD - 12 && n <= 6 * TD + 12, 1'b1)
      reclose_breaker();
      idle_wait();
      $display("test final trip done");
      // slow mechanism recovery with the per-cycle check on
      cfg.num_cycles = 4'h1;
      cfg.per_cycle_ready_check = 1'b1;
      for (int r = 0; r < 4; r++)
      begin
         rec = 16'(recs[r]);
         cfg.breaker_recovery_timeout = tmos[r];
         shot(r < 2, (r == 0) ? 5 + 4 * TD : 53);
         if (r >= 2) `CHK(st.reclose_not_ready_flag, 1'b1)
         reclose_breaker();
         idle_wait();
      end
      tick(200);
      $display("test recovery done");
      // trip while the breaker reports not ready
      hold_rdy = 1'b1;
      tick(2);
      shot(1'b0, 0);
      hold_rdy = 1'b0;
      reclose_breaker();
      idle_wait();
      $display("test not ready done");
      // static blocking by position and by the block input
      cfg.per_cycle_ready_check = 1'b0;
      for (int f = 0; f < 5; f++)
      begin
         cfg.aux_cfg = (f < 2) ? BRM_AUX_OPEN : BRM_AUX_BOTH;
         fpos = fcs[f];
         blk = (f == 4);
         tick(3);
         `CHK(st.reclose_blocked_flag, exp_blk[f])
         if (f != 1 && f != 4) `CHK(st.breaker_not_ready_flag, 1'b1)
         blk = 1'b0;
         reclose_breaker();
         tick(3);
      end
      $display("test static block done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
